// ===== include/rx_profile_pkg.sv
/*
 * constants for the receiver / lo-chain profile register slice:
 * byte offsets, writable-bit masks, reset values and field positions.
 * assumes the serial control core presents byte-wide accesses at these offsets.
 */
package rx_profile_pkg;

   // register port geometry
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam int NUM_REGS = 8;
   localparam int IDX_W = 3;

   // register offsets on the serial control port
   localparam logic [ADDR_W-1:0] OFF_RX_PROFILE14_GAIN_CH12 = 10'h06B;
   localparam logic [ADDR_W-1:0] OFF_RX_PROFILE14_GAIN_CH34 = 10'h06C;
   localparam logic [ADDR_W-1:0] OFF_RX_PROFILE15_ENABLES = 10'h06D;
   localparam logic [ADDR_W-1:0] OFF_RX_PROFILE15_GAIN_CH12 = 10'h06E;
   localparam logic [ADDR_W-1:0] OFF_RX_PROFILE15_GAIN_CH34 = 10'h06F;
   localparam logic [ADDR_W-1:0] OFF_LO_CHAIN_PROFILE0 = 10'h070;
   localparam logic [ADDR_W-1:0] OFF_LO_CHAIN_PROFILE1 = 10'h071;
   localparam logic [ADDR_W-1:0] OFF_LO_CHAIN_PROFILE2 = 10'h072;

   // storage index of each register
   localparam logic [IDX_W-1:0] IDX_P14_CH12 = 3'h0;
   localparam logic [IDX_W-1:0] IDX_P14_CH34 = 3'h1;
   localparam logic [IDX_W-1:0] IDX_P15_EN = 3'h2;
   localparam logic [IDX_W-1:0] IDX_P15_CH12 = 3'h3;
   localparam logic [IDX_W-1:0] IDX_P15_CH34 = 3'h4;
   localparam logic [IDX_W-1:0] IDX_LO0 = 3'h5;
   localparam logic [IDX_W-1:0] IDX_LO1 = 3'h6;
   localparam logic [IDX_W-1:0] IDX_LO2 = 3'h7;

   // offset table, in index order
   localparam logic [ADDR_W-1:0] REG_OFFSET [NUM_REGS] = '{
      OFF_RX_PROFILE14_GAIN_CH12, OFF_RX_PROFILE14_GAIN_CH34, OFF_RX_PROFILE15_ENABLES,
      OFF_RX_PROFILE15_GAIN_CH12, OFF_RX_PROFILE15_GAIN_CH34, OFF_LO_CHAIN_PROFILE0,
      OFF_LO_CHAIN_PROFILE1, OFF_LO_CHAIN_PROFILE2};

   // writable bits; zeros are reserved and read as zero
   localparam logic [DATA_W-1:0] GAIN_MASK = 8'h77;
   localparam logic [DATA_W-1:0] ENABLE_MASK = 8'h7F;
   localparam logic [DATA_W-1:0] LO_MASK = 8'hFF;
   localparam logic [DATA_W-1:0] REG_MASK [NUM_REGS] = '{
      GAIN_MASK, GAIN_MASK, ENABLE_MASK, GAIN_MASK, GAIN_MASK, LO_MASK, LO_MASK, LO_MASK};

   // reset values
   localparam logic [DATA_W-1:0] RST_GAIN = 8'h00;
   localparam logic [DATA_W-1:0] RST_P15_EN = 8'h7F;
   localparam logic [DATA_W-1:0] RST_LO0 = 8'h00;
   localparam logic [DATA_W-1:0] RST_LO1 = 8'h6A;
   localparam logic [DATA_W-1:0] RST_LO2 = 8'hFA;
   localparam logic [DATA_W-1:0] REG_RESET [NUM_REGS] = '{
      RST_GAIN, RST_GAIN, RST_P15_EN, RST_GAIN, RST_GAIN, RST_LO0, RST_LO1, RST_LO2};

   // field positions: gain registers
   localparam int GAIN_HI_MSB = 6;
   localparam int GAIN_HI_LSB = 4;
   localparam int GAIN_LO_MSB = 2;
   localparam int GAIN_LO_LSB = 0;
   localparam int GAIN_RSV_HI = 7;
   localparam int GAIN_RSV_LO = 3;

   // field positions: profile 15 enable register
   localparam int EN_MAIN_SPLIT = 6;
   localparam int EN_PAIR_A_SPLIT = 5;
   localparam int EN_PAIR_B_SPLIT = 4;
   localparam int EN_CH1 = 3;
   localparam int EN_CH2 = 2;
   localparam int EN_CH3 = 1;
   localparam int EN_CH4 = 0;

   // field positions: lo chain profile registers
   localparam int LO_FILTER_SEL = 7;
   localparam int LO_AMP_ON = 6;
   localparam int LO_LOW_PREP = 5;
   localparam int LO_LOW_LIVE = 4;
   localparam int LO_MID_PREP = 3;
   localparam int LO_MID_LIVE = 2;
   localparam int LO_HIGH_PREP = 1;
   localparam int LO_HIGH_LIVE = 0;

endpackage : rx_profile_pkg

// ===== hdl/rx_mult_mode_profile_regs.sv
/*
 * profile register slice: receiver profiles 14/15 gain and enable registers
 * and lo chain multiplier/filter profiles 0 to 2, with byte read/write port.
 * assumes the serial control core runs on clk_i and presents one-cycle
 * read and write strobes; the profile sequencers consume the field outputs.
 */
// Overview of operation
// R1: profile 14 ch1/ch2 gains, reserved zero
// R2: profile 14 ch3/ch4 gains, reserved zero
// R3: profile 15 splitter/channel enables reset one
// R4: profile 15 ch1/ch2 gains writable, reset zero
// R5: profile 15 ch3/ch4 gains writable, reset zero
// R6: lo profile bit order filter, amp, bands
// R7: lo profile 0 resets all zero
// R8: lo profile 1 resets amp and ready
// R9: lo profile 2 resets filter, amp, ready, lowlive
// R10: profile 15 channel 4 enable bit 0
// R11: reserved bits ignore writes, read zero
// R12: fields presented continuously to sequencer
`timescale 1ns/100ps
module rx_mult_mode_profile_regs
   import rx_profile_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   output logic [DATA_W-1:0] rdata_o,
   output logic rd_valid_o,
   output logic [2:0] profile14_first_channel_gain_o,
   output logic [2:0] profile14_second_channel_gain_o,
   output logic [2:0] profile14_third_channel_gain_o,
   output logic [2:0] profile14_fourth_channel_gain_o,
   output logic profile15_main_splitter_on_o,
   output logic profile15_pair_a_splitter_on_o,
   output logic profile15_pair_b_splitter_on_o,
   output logic profile15_first_channel_on_o,
   output logic profile15_second_channel_on_o,
   output logic profile15_third_channel_on_o,
   output logic profile15_fourth_channel_on_o,
   output logic [2:0] profile15_first_channel_gain_o,
   output logic [2:0] profile15_second_channel_gain_o,
   output logic [2:0] profile15_third_channel_gain_o,
   output logic [2:0] profile15_fourth_channel_gain_o,
   output logic [DATA_W-1:0] lo_profile0_o,
   output logic [DATA_W-1:0] lo_profile1_o,
   output logic [DATA_W-1:0] lo_profile2_o
);

   // offset decode: bit IDX_W is the hit flag, low bits the index
   function automatic logic [IDX_W:0] decode_offset(input logic [ADDR_W-1:0] a);
      logic [IDX_W:0] r;
      r = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (a == REG_OFFSET[i]) begin
            r = {1'b1, IDX_W'(i)};
         end
      end
      return r;
   endfunction : decode_offset

   logic [IDX_W:0] dec_w;
   logic [NUM_REGS-1:0] wr_sel;
   logic [NUM_REGS-1:0][DATA_W-1:0] regs_w;
   logic [DATA_W-1:0] rd_mux;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic rd_valid_q;

   // address decode and read selection
   assign dec_w = decode_offset(addr_i);
   assign rd_mux = dec_w[IDX_W] ? regs_w[dec_w[IDX_W-1:0]] : '0; // unmapped reads zero
   assign rdata_d = rd_en_i ? rd_mux : rdata_q;

   // one storage byte per register; reserved bits never stored
   for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      logic [DATA_W-1:0] byte_q;
      assign wr_sel[g] = wr_en_i && dec_w[IDX_W] && (dec_w[IDX_W-1:0] == IDX_W'(g));
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            byte_q <= REG_RESET[g]; // R1 R2 R3 R4 R5 R7 R8 R9 R10
         end else if (wr_sel[g]) begin
            byte_q <= wdata_i & REG_MASK[g]; // R11
         end
      end
      assign regs_w[g] = byte_q;
   end

   // read data register, held between reads
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= '0;
         rd_valid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d; // R11
         rd_valid_q <= rd_en_i;
      end
   end

   assign rdata_o = rdata_q;
   assign rd_valid_o = rd_valid_q;

   // gain fields of profiles 14 and 15, straight from storage
   assign profile14_first_channel_gain_o = regs_w[IDX_P14_CH12][GAIN_HI_MSB:GAIN_HI_LSB]; // R1 R12
   assign profile14_second_channel_gain_o = regs_w[IDX_P14_CH12][GAIN_LO_MSB:GAIN_LO_LSB]; // R1
   assign profile14_third_channel_gain_o = regs_w[IDX_P14_CH34][GAIN_HI_MSB:GAIN_HI_LSB]; // R2
   assign profile14_fourth_channel_gain_o = regs_w[IDX_P14_CH34][GAIN_LO_MSB:GAIN_LO_LSB]; // R2
   assign profile15_first_channel_gain_o = regs_w[IDX_P15_CH12][GAIN_HI_MSB:GAIN_HI_LSB]; // R4
   assign profile15_second_channel_gain_o = regs_w[IDX_P15_CH12][GAIN_LO_MSB:GAIN_LO_LSB]; // R4
   assign profile15_third_channel_gain_o = regs_w[IDX_P15_CH34][GAIN_HI_MSB:GAIN_HI_LSB]; // R5
   assign profile15_fourth_channel_gain_o = regs_w[IDX_P15_CH34][GAIN_LO_MSB:GAIN_LO_LSB]; // R5

   // profile 15 splitter and channel enables
   assign profile15_main_splitter_on_o = regs_w[IDX_P15_EN][EN_MAIN_SPLIT]; // R3
   assign profile15_pair_a_splitter_on_o = regs_w[IDX_P15_EN][EN_PAIR_A_SPLIT]; // R3
   assign profile15_pair_b_splitter_on_o = regs_w[IDX_P15_EN][EN_PAIR_B_SPLIT]; // R3
   assign profile15_first_channel_on_o = regs_w[IDX_P15_EN][EN_CH1]; // R3
   assign profile15_second_channel_on_o = regs_w[IDX_P15_EN][EN_CH2]; // R3
   assign profile15_third_channel_on_o = regs_w[IDX_P15_EN][EN_CH3]; // R3
   assign profile15_fourth_channel_on_o = regs_w[IDX_P15_EN][EN_CH4]; // R10

   // lo chain profiles, whole byte in field order
   assign lo_profile0_o = regs_w[IDX_LO0]; // R6 R12
   assign lo_profile1_o = regs_w[IDX_LO1]; // R6
   assign lo_profile2_o = regs_w[IDX_LO2]; // R6

   // checks on stored fields and read data
   a_p14_ch12_write: assert property (@(posedge clk_i) disable iff (rst_i) // R1
      wr_en_i && addr_i == OFF_RX_PROFILE14_GAIN_CH12 |=>
      profile14_first_channel_gain_o == $past(wdata_i[6:4]) && profile14_second_channel_gain_o == $past(wdata_i[2:0]))
      else $error("profile 14 ch1/ch2 gain not stored");
   a_p14_ch34_write: assert property (@(posedge clk_i) disable iff (rst_i) // R2
      wr_en_i && addr_i == OFF_RX_PROFILE14_GAIN_CH34 |=>
      profile14_third_channel_gain_o == $past(wdata_i[6:4]) && profile14_fourth_channel_gain_o == $past(wdata_i[2:0]))
      else $error("profile 14 ch3/ch4 gain not stored");
   a_p15_en_reset: assert property (@(posedge clk_i) // R3
      $past(rst_i) && !rst_i |-> profile15_main_splitter_on_o && profile15_pair_a_splitter_on_o
      && profile15_pair_b_splitter_on_o && profile15_first_channel_on_o && profile15_second_channel_on_o
      && profile15_third_channel_on_o)
      else $error("profile 15 enables not one after reset");
   a_p15_ch12_write: assert property (@(posedge clk_i) disable iff (rst_i) // R4
      wr_en_i && addr_i == OFF_RX_PROFILE15_GAIN_CH12 |=>
      {profile15_first_channel_gain_o, profile15_second_channel_gain_o} == $past({wdata_i[6:4], wdata_i[2:0]}))
      else $error("profile 15 ch1/ch2 gain not stored");
   a_p15_ch34_write: assert property (@(posedge clk_i) disable iff (rst_i) // R5
      wr_en_i && addr_i == OFF_RX_PROFILE15_GAIN_CH34 |=>
      {profile15_third_channel_gain_o, profile15_fourth_channel_gain_o} == $past({wdata_i[6:4], wdata_i[2:0]}))
      else $error("profile 15 ch3/ch4 gain not stored");
   a_lo_bit_order: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      wr_en_i && addr_i == OFF_LO_CHAIN_PROFILE1 ##1 rd_en_i && addr_i == OFF_LO_CHAIN_PROFILE1 && !wr_en_i
      |=> rdata_o == $past(wdata_i, 2) && lo_profile1_o == rdata_o)
      else $error("lo profile byte not read back in order");
   a_lo0_reset_zero: assert property (@(posedge clk_i) // R7
      $past(rst_i) && !rst_i |-> lo_profile0_o == RST_LO0)
      else $error("lo profile 0 not zero after reset");
   a_lo1_reset_val: assert property (@(posedge clk_i) // R8
      $past(rst_i) && !rst_i |-> lo_profile1_o == RST_LO1)
      else $error("lo profile 1 reset value wrong");
   a_lo2_reset_val: assert property (@(posedge clk_i) // R9
      $past(rst_i) && !rst_i |-> lo_profile2_o == RST_LO2)
      else $error("lo profile 2 reset value wrong");
   a_ch4_enable_bit: assert property (@(posedge clk_i) disable iff (rst_i) // R10
      wr_en_i && addr_i == OFF_RX_PROFILE15_ENABLES |=> profile15_fourth_channel_on_o == $past(wdata_i[0]))
      else $error("profile 15 channel 4 enable not at bit 0");
   a_reserved_read_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      rd_en_i && (addr_i == OFF_RX_PROFILE14_GAIN_CH12 || addr_i == OFF_RX_PROFILE15_GAIN_CH34)
      |=> rd_valid_o && rdata_o[7] == 1'b0 && rdata_o[3] == 1'b0)
      else $error("reserved gain bits read nonzero");
   a_fields_held: assert property (@(posedge clk_i) disable iff (rst_i) // R12
      !wr_en_i |=> $stable(lo_profile0_o) && $stable(profile14_first_channel_gain_o)
      && $stable(profile15_fourth_channel_on_o))
      else $error("profile fields changed without a write");

   // read port behaviour and unmapped offsets
   a_read_valid_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      !$past(rst_i) |-> rd_valid_o == $past(rd_en_i))
      else $error("read valid not one cycle after each read strobe");
   a_read_data_held: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      !rd_en_i |=> $stable(rdata_o))
      else $error("read data changed without a read");
   a_rdata_reset_zero: assert property (@(posedge clk_i) // R11
      $past(rst_i) && !rst_i |-> rdata_o == '0 && !rd_valid_o)
      else $error("read port not idle after reset");
   a_unmapped_read_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      rd_en_i && !dec_w[IDX_W] |=> rd_valid_o && rdata_o == '0)
      else $error("unmapped offset did not read zero");
   a_unmapped_write_kept: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      wr_en_i && !dec_w[IDX_W] |=> $stable(regs_w))
      else $error("write to unmapped offset changed a register");

   // field order of the enable register, lo chain bytes and gain reset
   a_p15_en_write: assert property (@(posedge clk_i) disable iff (rst_i) // R3
      wr_en_i && addr_i == OFF_RX_PROFILE15_ENABLES |=> {profile15_main_splitter_on_o, profile15_pair_a_splitter_on_o,
      profile15_pair_b_splitter_on_o, profile15_first_channel_on_o, profile15_second_channel_on_o,
      profile15_third_channel_on_o, profile15_fourth_channel_on_o} == $past(wdata_i[EN_MAIN_SPLIT:EN_CH4]))
      else $error("profile 15 enable bits not stored in order");
   a_lo0_write: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      wr_en_i && addr_i == OFF_LO_CHAIN_PROFILE0 |=> lo_profile0_o == $past(wdata_i))
      else $error("lo profile 0 byte not stored");
   a_lo1_write: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      wr_en_i && addr_i == OFF_LO_CHAIN_PROFILE1 |=> lo_profile1_o == $past(wdata_i))
      else $error("lo profile 1 byte not stored");
   a_lo2_write: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      wr_en_i && addr_i == OFF_LO_CHAIN_PROFILE2 |=> lo_profile2_o == $past(wdata_i))
      else $error("lo profile 2 byte not stored");
   a_gain_reset_zero: assert property (@(posedge clk_i) // R1
      $past(rst_i) && !rst_i |-> {profile14_first_channel_gain_o, profile14_second_channel_gain_o,
      profile14_third_channel_gain_o, profile14_fourth_channel_gain_o} == '0)
      else $error("profile 14 gains not zero after reset");

   // main scenarios
   c_write_then_read: cover property (@(posedge clk_i) disable iff (rst_i)
      wr_en_i && addr_i == OFF_LO_CHAIN_PROFILE2 ##1 rd_en_i && addr_i == OFF_LO_CHAIN_PROFILE2);
   c_unmapped_read: cover property (@(posedge clk_i) disable iff (rst_i)
      rd_en_i && !dec_w[IDX_W]);
   c_enables_cleared: cover property (@(posedge clk_i) disable iff (rst_i)
      wr_en_i && addr_i == OFF_RX_PROFILE15_ENABLES && wdata_i == 8'h00);
   c_lo1_write_read: cover property (@(posedge clk_i) disable iff (rst_i)
      wr_en_i && addr_i == OFF_LO_CHAIN_PROFILE1 ##1 rd_en_i && addr_i == OFF_LO_CHAIN_PROFILE1);
   c_mid_run_reset: cover property (@(posedge clk_i)
      !rst_i ##1 rst_i ##1 rst_i ##1 !rst_i);

endmodule : rx_mult_mode_profile_regs

// ===== verif/test_rx_mult_mode_profile_regs.sv
/*
 * self-checking bench for the profile register slice: reset values, masked writes,
 * field mapping on the output ports, unmapped offsets and a second reset.
 * assumes the package constants for offsets and the design's one-cycle read answer.
 */
`timescale 1ns/100ps
module test_rx_mult_mode_profile_regs;
   import rx_profile_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wr_en_i = 1'b0;
   logic rd_en_i = 1'b0;
   logic [ADDR_W-1:0] addr_i = '0;
   logic [DATA_W-1:0] wdata_i = '0;
   logic [DATA_W-1:0] rdata_o, lo0, lo1, lo2, got;
   logic rd_valid_o;
   logic [2:0] g14a, g14b, g14c, g14d, g15a, g15b, g15c, g15d;
   logic [6:0] en15;
   logic [DATA_W-1:0] view [NUM_REGS];
   logic [DATA_W-1:0] exp_v [NUM_REGS];
   int bad_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   // expected contents, worked out from the field tables
   localparam logic [7:0] EXP_RST [NUM_REGS] = '{8'h00, 8'h00, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h6A, 8'hFA};
   localparam logic [7:0] WMASK [NUM_REGS] = '{8'h77, 8'h77, 8'h7F, 8'h77, 8'h77, 8'hFF, 8'hFF, 8'hFF};
   localparam logic [7:0] PAT [NUM_REGS] = '{8'hA5, 8'h9E, 8'hAA, 8'h61, 8'h3C, 8'h01, 8'h80, 8'h55};
   localparam logic [7:0] ALL_FF [NUM_REGS] = '{default: 8'hFF};
   localparam logic [7:0] ALL_00 [NUM_REGS] = '{default: 8'h00};

   always #25 clk_i = ~clk_i;

   rx_mult_mode_profile_regs dut (
      .clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .rdata_o(rdata_o), .rd_valid_o(rd_valid_o),
      .profile14_first_channel_gain_o(g14a), .profile14_second_channel_gain_o(g14b),
      .profile14_third_channel_gain_o(g14c), .profile14_fourth_channel_gain_o(g14d),
      .profile15_main_splitter_on_o(en15[6]), .profile15_pair_a_splitter_on_o(en15[5]),
      .profile15_pair_b_splitter_on_o(en15[4]), .profile15_first_channel_on_o(en15[3]),
      .profile15_second_channel_on_o(en15[2]), .profile15_third_channel_on_o(en15[1]),
      .profile15_fourth_channel_on_o(en15[0]),
      .profile15_first_channel_gain_o(g15a), .profile15_second_channel_gain_o(g15b),
      .profile15_third_channel_gain_o(g15c), .profile15_fourth_channel_gain_o(g15d),
      .lo_profile0_o(lo0), .lo_profile1_o(lo1), .lo_profile2_o(lo2));

   // field ports reassembled into register images
   assign view[0] = {1'b0, g14a, 1'b0, g14b};
   assign view[1] = {1'b0, g14c, 1'b0, g14d};
   assign view[2] = {1'b0, en15};
   assign view[3] = {1'b0, g15a, 1'b0, g15b};
   assign view[4] = {1'b0, g15c, 1'b0, g15d};
   assign view[5] = lo0;
   assign view[6] = lo1;
   assign view[7] = lo2;

   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string what);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
      end
   endtask : chk_byte

   task automatic chk_flag(input logic g, input logic e, input string what);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t %s got %b exp %b", $time, what, g, e);
      end
   endtask : chk_flag

   // one read: strobe for one cycle, answer sampled after the next edge
   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk_i);
      rd_en_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_en_i <= 1'b0;
      #1;
      chk_flag(rd_valid_o, 1'b1, "read answer valid");
      d = rdata_o;
   endtask : rd_reg

   // write, then read the same offset at the very next edge
   task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r);
      @(posedge clk_i);
      wr_en_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_en_i <= 1'b0;
      rd_en_i <= 1'b1;
      @(posedge clk_i);
      rd_en_i <= 1'b0;
      #1;
      chk_flag(rd_valid_o, 1'b1, "read after write valid");
      r = rdata_o;
   endtask : wr_rd

   // single write, strobe dropped at the following edge
   task automatic wr_one(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_i);
      wr_en_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_en_i <= 1'b0;
   endtask : wr_one

   // back-to-back writes to all eight registers
   task automatic fill_all(input logic [7:0] d [NUM_REGS]);
      for (int i = 0; i < NUM_REGS; i++) begin
         @(posedge clk_i);
         wr_en_i <= 1'b1;
         addr_i <= REG_OFFSET[i];
         wdata_i <= d[i];
      end
      @(posedge clk_i);
      wr_en_i <= 1'b0;
   endtask : fill_all

   // read back every register and compare with its field ports too
   task automatic check_all(input logic [7:0] e [NUM_REGS]);
      logic [7:0] d;
      for (int i = 0; i < NUM_REGS; i++) begin
         rd_reg(REG_OFFSET[i], d);
         chk_byte(d, e[i], "read back");
         chk_byte(view[i], e[i], "field ports");
      end
   endtask : check_all

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test

   // hang guard, well above the under two hundred cycles the tests need
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         $display("[FAIL] %0t run did not finish", $time);
         end_of_test();
      end
   end

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      check_all(EXP_RST);
      $display("test reset values done");
      fill_all(ALL_FF);
      check_all(WMASK);
      $display("test all ones done");
      for (int i = 0; i < NUM_REGS; i++) begin
         exp_v[i] = PAT[i] & WMASK[i];
      end
      fill_all(PAT);
      check_all(exp_v);
      $display("test field mapping done");
      fill_all(ALL_00);
      check_all(ALL_00);
      $display("test all zeros done");
      wr_one(10'h06A, 8'hFF);
      wr_one(10'h073, 8'hFF);
      rd_reg(10'h073, got);
      chk_byte(got, 8'h00, "unmapped read");
      check_all(ALL_00);
      $display("test unmapped offsets done");
      wr_rd(OFF_LO_CHAIN_PROFILE1, 8'h81, got);
      chk_byte(got, 8'h81, "write then read");
      chk_byte(lo1, 8'h81, "lo profile 1 port");
      wr_rd(OFF_LO_CHAIN_PROFILE2, 8'h3C, got);
      chk_byte(got, 8'h3C, "write then read");
      chk_byte(lo2, 8'h3C, "lo profile 2 port");
      $display("test write then read done");
      fill_all(ALL_FF);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk_flag(rd_valid_o, 1'b0, "valid after reset");
      check_all(EXP_RST);
      $display("test second reset done");
      end_of_test();
   end
endmodule : test_rx_mult_mode_profile_regs
